// file: verilog/pcd_pkg.sv
/*
   Constants for the command-word decoder of the interrupt controller:
   word select codes, first-word field positions, reset values.
   Assumes a single 40 MHz clock domain.
*/
package pcd_pkg;
   // Register select values
   localparam logic       SEL_LOW        = 1'b0;
   localparam logic       SEL_HIGH       = 1'b1;
   // First-word field positions and the runtime-word select bit
   localparam int         FW_FOURTH_POS  = 0;
   localparam int         FW_SINGLE_POS  = 1;
   localparam int         FW_SPACING_POS = 2;
   localparam int         FW_LEVEL_POS   = 3;
   localparam int         FW_MARK_POS    = 4;
   localparam int         FW_VEC_LO_POS  = 5;
   localparam int         FW_VEC_HI_POS  = 7;
   localparam int         OP_SEL_POS     = 3;
   // Reset values
   localparam logic [7:0] WORD_RST       = 8'h00;
   localparam logic [2:0] VEC_RST        = 3'h0;
   // Fourth-word defaults: non-buffered, no auto end, 3-byte sequence
   localparam logic [7:0] FOURTH_DEFAULT = 8'h00;
   // Initialization progress
   typedef enum logic [2:0] {
      PCD_IDLE   = 3'b000,
      PCD_WAIT2  = 3'b001,
      PCD_WAIT3  = 3'b010,
      PCD_WAIT4  = 3'b011,
      PCD_READY  = 3'b100
   } pcd_state_e;
endpackage

// file: verilog/pcd_decoder.sv
/*
   Host-bus front end of an 8-input interrupt controller: decodes writes
   into setup and runtime command words and runs the setup order.
   Assumes asynchronous host strobes, synchronised here, and a host that
   holds chip select and write low for at least one whole clock.
   Data and strobes share one synchroniser, so the host must settle the
   data no later than the strobe. Reads give only a strobe, no data.
*/
// Notes on behaviour
// - Select low, data bit four high starts setup
// - Setup words follow in order, write-strobe paced
// - Second setup word always follows the first
// - Third word expected only in cascade mode
// - Fourth word expected only when flagged
// - Runtime words decoded by select and bits
// - Strobes sampled on the rising clock edge
// - First word deselects on write strobe fall
// - Fourth flag low clears fourth-word settings
// - Bit one high means single, low cascade
// - Bit two selects vector spacing four/eight
// - Bit three selects level or edge requests
// - Bit four with select marks first word
// - Bits five to seven store vector bits
// - Reset restores defaults, waits for setup
// - Later setup words deselect on strobe fall
// - Setup ends after last needed word
`timescale 1ns/1ps
module pcd_decoder
(
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rstn,
   // Host bus pins
   input  wire logic       i_cs_n,
   input  wire logic       i_wr_n,
   input  wire logic       i_rd_n,
   input  wire logic       i_register_select,
   input  wire logic [7:0] i_din,
   // Stored setup words
   output logic [7:0]      o_setup_word_two,
   output logic [7:0]      o_setup_word_three,
   output logic [7:0]      o_setup_word_four,
   // Stored runtime words
   output logic [7:0]      o_runtime_word_one,
   output logic [7:0]      o_runtime_word_two,
   output logic [7:0]      o_runtime_word_three,
   // Mode fields from the first word
   output logic            o_fourth_word_needed,
   output logic            o_single_mode,
   output logic            o_vector_spacing_sel,
   output logic            o_level_trigger_sel,
   output logic [2:0]      o_vector_bits,
   // Status and strobes
   output logic            o_init_done,
   output logic            o_read_strobe,
   output logic            o_runtime_two_pulse,
   output logic            o_runtime_three_pulse
);
   import pcd_pkg::*;

   // Two-stage synchronisers; the first stage feeds only the second
   logic [11:0] sync1_ff;        // Raw capture
   logic [11:0] sync2_ff;        // Safe copy
   logic        wr_act_d_ff;     // Previous synchronised write state

   // State and stored words
   pcd_state_e  state_ff;        // Setup step reached so far
   pcd_state_e  nxt_state;       // Step after this clock
   logic [7:0]  w2_ff;           // Setup word two
   logic [7:0]  w3_ff;           // Setup word three, cascade only
   logic [7:0]  w4_ff;           // Setup word four or its defaults
   logic [7:0]  r1_ff;           // Runtime word one
   logic [7:0]  r2_ff;           // Runtime word two
   logic [7:0]  r3_ff;           // Runtime word three
   logic        fourth_ff;       // Fourth word needed
   logic        single_ff;       // Single, not cascaded
   logic        spacing_ff;      // Vector spacing select
   logic        level_ff;        // Level-triggered requests
   logic [2:0]  vec_ff;          // Vector bits five to seven
   logic        done_ff;         // Setup complete
   logic        rd_ff;           // Registered read strobe
   logic        p2_ff;           // Runtime word two pulse
   logic        p3_ff;           // Runtime word three pulse

   // Decoded synchronised pins
   wire         s_cs_n   = sync2_ff[11];
   wire         s_wr_n   = sync2_ff[10];
   wire         s_rd_n   = sync2_ff[9];
   wire         s_sel    = sync2_ff[8];
   wire  [7:0]  s_din    = sync2_ff[7:0];
   wire         wr_act   = !s_cs_n && !s_wr_n;
   // One take per write: the first sampled cycle of the low strobe.
   // The strobe fall both takes a word and deselects it, the first word
   // included; the rise only re-arms the edge detector for the next take.
   wire         wr_take  = wr_act && !wr_act_d_ff;
   wire         rd_act   = !s_cs_n && !s_rd_n;
   wire         is_first = wr_take && (s_sel == SEL_LOW)
                           && s_din[FW_MARK_POS];
   wire         hi_take  = wr_take && (s_sel == SEL_HIGH);
   // Select low with bit four low is a runtime word; bit three picks it
   wire         op_low   = wr_take && (s_sel == SEL_LOW)
                           && !s_din[FW_MARK_POS];
   // Runtime words are refused until setup has finished
   wire         op2_take = op_low && !s_din[OP_SEL_POS] && done_ff;
   wire         op3_take = op_low && s_din[OP_SEL_POS] && done_ff;
   wire         op1_take = hi_take && (state_ff == PCD_READY);
   // Step after the second or third word, from the stored flags
   wire pcd_state_e after2 = !single_ff ? PCD_WAIT3
                           : (fourth_ff ? PCD_WAIT4 : PCD_READY);
   wire pcd_state_e after3 = fourth_ff ? PCD_WAIT4 : PCD_READY;

   // Next state of the setup sequencer
   always_comb
   begin
      // Hold the step unless a write is taken
      nxt_state = state_ff;
      // A first word wins over any step in progress
      if (is_first)
      begin
         nxt_state = PCD_WAIT2;
      end
      // Select-high writes pace the later setup words
      else if (hi_take)
      begin
         case (state_ff)
            PCD_WAIT2: nxt_state = after2;
            PCD_WAIT3: nxt_state = after3;
            PCD_WAIT4: nxt_state = PCD_READY;
            // Never set up: select-high writes change nothing
            PCD_IDLE:  nxt_state = PCD_IDLE;
            PCD_READY: nxt_state = PCD_READY;
            default:   nxt_state = PCD_IDLE;
         endcase
      end
   end

   // Pin synchronisers
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         // Idle pin levels, so no false strobe edge follows release
         sync1_ff    <= 12'hfff;
         sync2_ff    <= 12'hfff;
         wr_act_d_ff <= 1'b0;
      end
      else
      begin
         // Pins captured together keep data aligned with the strobes
         sync1_ff    <= {i_cs_n, i_wr_n, i_rd_n, i_register_select, i_din};
         sync2_ff    <= sync1_ff;
         wr_act_d_ff <= wr_act;
      end
   end

   // Sequencer state and done flag
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         state_ff <= PCD_IDLE;
         done_ff  <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         // Registered copy of the ready step drives the output directly
         done_ff  <= (nxt_state == PCD_READY);
      end
   end

   // First-word mode fields
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         fourth_ff  <= 1'b0;
         single_ff  <= 1'b0;
         spacing_ff <= 1'b0;
         level_ff   <= 1'b0;
         vec_ff     <= VEC_RST;
      end
      // Only a first word reloads the mode fields; they hold otherwise
      else if (is_first)
      begin
         fourth_ff  <= s_din[FW_FOURTH_POS];
         single_ff  <= s_din[FW_SINGLE_POS];
         spacing_ff <= s_din[FW_SPACING_POS];
         level_ff   <= s_din[FW_LEVEL_POS];
         vec_ff     <= s_din[FW_VEC_HI_POS:FW_VEC_LO_POS];
      end
   end

   // Setup words two to four
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         w2_ff <= WORD_RST;
         w3_ff <= WORD_RST;
         w4_ff <= WORD_RST;
      end
      else
      begin
         // Each later word lands in the slot of the step in progress
         if (hi_take && state_ff == PCD_WAIT2)
         begin
            w2_ff <= s_din;
         end
         // Reached only in cascade mode
         if (hi_take && state_ff == PCD_WAIT3)
         begin
            w3_ff <= s_din;
         end
         // Skipped fourth word falls back to its defaults
         if (is_first && !s_din[FW_FOURTH_POS])
         begin
            w4_ff <= FOURTH_DEFAULT;
         end
         else if (hi_take && state_ff == PCD_WAIT4)
         begin
            w4_ff <= s_din;
         end
      end
   end

   // Runtime words and strobes
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         r1_ff <= WORD_RST;
         r2_ff <= WORD_RST;
         r3_ff <= WORD_RST;
         p2_ff <= 1'b0;
         p3_ff <= 1'b0;
         rd_ff <= 1'b0;
      end
      else
      begin
         if (op1_take)
         begin
            r1_ff <= s_din;
         end
         if (op2_take)
         begin
            r2_ff <= s_din;
         end
         if (op3_take)
         begin
            r3_ff <= s_din;
         end
         // One-cycle pulses, one per taken runtime word two or three
         p2_ff <= op2_take;
         p3_ff <= op3_take;
         // A level, not a pulse; no read data lives in this block
         rd_ff <= rd_act;
      end
   end

   // Outputs straight from flip-flops
   assign o_setup_word_two      = w2_ff;
   assign o_setup_word_three    = w3_ff;
   assign o_setup_word_four     = w4_ff;
   assign o_runtime_word_one    = r1_ff;
   assign o_runtime_word_two    = r2_ff;
   assign o_runtime_word_three  = r3_ff;
   assign o_fourth_word_needed  = fourth_ff;
   assign o_single_mode         = single_ff;
   assign o_vector_spacing_sel  = spacing_ff;
   assign o_level_trigger_sel   = level_ff;
   assign o_vector_bits         = vec_ff;
   assign o_init_done           = done_ff;
   assign o_read_strobe         = rd_ff;
   assign o_runtime_two_pulse   = p2_ff;
   assign o_runtime_three_pulse = p3_ff;

   // Checks: all gathered here after the logic they guard; all clocked on the
   // system clock and disabled while reset is held, except the reset check
   AST_FIRST_RESTART: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      is_first |=> state_ff == PCD_WAIT2 && !done_ff)
      else $error("first word did not restart setup");
   AST_SECOND_FOLLOWS: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (hi_take && state_ff == PCD_WAIT2) |=> w2_ff == $past(s_din))
      else $error("second word not stored");
   AST_CASCADE_THIRD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (hi_take && state_ff == PCD_WAIT2 && !single_ff) |=> state_ff == PCD_WAIT3)
      else $error("cascade mode skipped third word");
   AST_FOURTH_SKIP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (hi_take && state_ff == PCD_WAIT3 && !fourth_ff) |=> done_ff)
      else $error("fourth word not skipped");
   AST_FOURTH_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (is_first && !s_din[FW_FOURTH_POS]) |=> w4_ff == FOURTH_DEFAULT)
      else $error("fourth-word settings not cleared");
   AST_FIELDS: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      is_first |=> vec_ff == $past(s_din[7:5]) && level_ff == $past(s_din[3]))
      else $error("first-word fields not stored");
   AST_EARLY_OP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (op_low && !done_ff) |=> $stable(r2_ff) && $stable(r3_ff))
      else $error("runtime word taken before setup done");
   // A held strobe takes nothing more after its one take
   AST_ONE_TAKE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (wr_act && wr_act_d_ff) |=> $stable(state_ff) && $stable(vec_ff) && $stable(w2_ff))
      else $error("write taken twice");
   // Done rises only on a taken select-high word
   AST_DONE_STATE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      $rose(done_ff) |-> $past(hi_take) && state_ff == PCD_READY)
      else $error("done flag rose without a last word");
   // Reset returns the sequencer and stored words to defaults
   AST_RESET_IDLE: assert property (@(posedge i_sys_clk)
      !i_rstn |=> state_ff == PCD_IDLE && !done_ff && w4_ff == WORD_RST && !rd_ff)
      else $error("reset did not restore defaults");
   // Select-high writes before any first word are ignored
   AST_IDLE_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (hi_take && state_ff == PCD_IDLE) |=> state_ff == PCD_IDLE && $stable(w2_ff))
      else $error("setup word taken before a first word");
   // Single mode never waits for a third word
   AST_SINGLE_ROUTE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (hi_take && state_ff == PCD_WAIT2 && single_ff) |=> state_ff != PCD_WAIT3)
      else $error("single mode expected a third word");
   // Bit four low never reloads the mode fields
   AST_FIELDS_KEEP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (wr_take && s_sel == SEL_LOW && !s_din[FW_MARK_POS])
      |=> $stable(vec_ff) && $stable(single_ff) && $stable(fourth_ff))
      else $error("runtime word changed the mode fields");
   // Runtime word one after setup, and the word-two pulse
   AST_OP_ONE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (hi_take && done_ff) |=> r1_ff == $past(s_din))
      else $error("runtime word one not stored");
   AST_OP_TWO: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      op2_take |=> p2_ff && r2_ff == $past(s_din))
      else $error("runtime word two not stored");

   // Coverage of the main scenarios
   COV_SINGLE: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
      state_ff == PCD_WAIT2 ##[1:40] done_ff);
   COV_FULL: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
      state_ff == PCD_WAIT4 ##[1:40] done_ff);
   COV_OP3: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) op3_take);
   // Restart while a cascade setup waits for its third word
   COV_RESTART: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
      is_first && state_ff == PCD_WAIT3);
endmodule // pcd_decoder

// file: verification/pcd_host_model.sv
/*
   Host processor model for the command-word decoder: drives chip select,
   strobes, register select and write data. Assumes a free-running system
   clock; every pin changes on its falling edge only.
*/
`timescale 1ns/1ps
module pcd_host_model
(
   // Clock
   input  wire logic       i_sys_clk,
   // Host bus pins
   output logic            o_cs_n,
   output logic            o_wr_n,
   output logic            o_rd_n,
   output logic            o_register_select,
   output logic [7:0]      o_din
);
   // Idle bus at time zero
   initial
   begin
      o_cs_n            = 1'b1;
      o_wr_n            = 1'b1;
      o_rd_n            = 1'b1;
      o_register_select = 1'b0;
      o_din             = 8'h00;
   end

   // One write: strobes low four clocks, then high four clocks so the
   // decoder's synchroniser and edge detector see a fresh low period
   task automatic wr(input logic sel, input logic [7:0] data);
      @(negedge i_sys_clk);
      o_register_select = sel;
      o_din             = data;
      o_cs_n            = 1'b0;
      o_wr_n            = 1'b0;
      repeat (4) @(negedge i_sys_clk);
      o_cs_n            = 1'b1;
      o_wr_n            = 1'b1;
      // Released bus must not keep showing the old data
      o_din             = ~data;
      repeat (4) @(negedge i_sys_clk);
   endtask

   // Read strobe level; the block returns no data, only a strobe
   task automatic rd_level(input logic lvl);
      @(negedge i_sys_clk);
      o_cs_n = lvl;
      o_rd_n = lvl;
   endtask
endmodule // pcd_host_model

// file: verification/pcd_decoder_tb.sv
/*
   Self-checking bench for the command-word decoder: host writes through
   the model, expected values from the word layout. Assumes one clock.
*/
`timescale 1ns/1ps
module pcd_decoder_tb;
   import pcd_pkg::*;
   logic       sys_clk, rstn, cs_n, wr_n, rd_n, sel, done, rstrobe, p2, p3;
   logic [7:0] din, w2, w3, w4, r1, r2, r3;
   logic       fourth, single, spacing, level;
   logic [2:0] vec;
   int         error_cnt = 0, n_tests = 0, cyc = 0, n_p2 = 0, n_p3 = 0;
   // First-word fields packed back into their bit places
   wire logic [7:0] fields = {vec, 1'b1, level, spacing, single, fourth};

   pcd_host_model pcd_host_model_inst (.i_sys_clk(sys_clk), .o_cs_n(cs_n),
      .o_wr_n(wr_n), .o_rd_n(rd_n), .o_register_select(sel), .o_din(din));
   pcd_decoder pcd_decoder_inst (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_cs_n(cs_n),
      .i_wr_n(wr_n), .i_rd_n(rd_n), .i_register_select(sel), .i_din(din),
      .o_setup_word_two(w2), .o_setup_word_three(w3), .o_setup_word_four(w4),
      .o_runtime_word_one(r1), .o_runtime_word_two(r2), .o_runtime_word_three(r3),
      .o_fourth_word_needed(fourth), .o_single_mode(single),
      .o_vector_spacing_sel(spacing), .o_level_trigger_sel(level),
      .o_vector_bits(vec), .o_init_done(done), .o_read_strobe(rstrobe),
      .o_runtime_two_pulse(p2), .o_runtime_three_pulse(p3));

   // 40 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Count one-cycle pulses; a hang past the ceiling ends the run
   always @(posedge sys_clk)
   begin
      cyc++;
      if (p2 === 1'b1) n_p2++;
      if (p3 === 1'b1) n_p3++;
      if (cyc == 2000)
      begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic words(input logic [7:0] e2, e3, e4, e1, f2, f3);
      chk("setup two", w2, e2);
      chk("setup three", w3, e3);
      chk("setup four", w4, e4);
      chk("runtime one", r1, e1);
      chk("runtime two", r2, f2);
      chk("runtime three", r3, f3);
   endtask

   // Reset held six clocks, applied off the sampling edge
   task automatic do_reset();
      @(negedge sys_clk);
      rstn = 1'b0;
      repeat (6) @(negedge sys_clk);
      rstn = 1'b1;
      @(negedge sys_clk);
   endtask

   task automatic end_sim();
      if (error_cnt == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      rstn = 1'b0;
      do_reset();
      words(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      chk("fields", fields, 8'h10);
      chk("done", {7'h00, done}, 8'h00);
      // Runtime writes before setup must leave nothing behind
      pcd_host_model_inst.wr(1'b1, 8'h5a);
      pcd_host_model_inst.wr(1'b0, 8'h08);
      pcd_host_model_inst.wr(1'b0, 8'h00);
      words(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      chk("pulses", n_p2[7:0] + n_p3[7:0], 8'h00);
      // Cascade with fourth word: every setup word in turn
      pcd_host_model_inst.wr(1'b0, 8'hbd);
      chk("fields", fields, 8'hbd);
      pcd_host_model_inst.wr(1'b1, 8'h11);
      chk("done", {7'h00, done}, 8'h00);
      pcd_host_model_inst.wr(1'b1, 8'h22);
      chk("done", {7'h00, done}, 8'h00);
      pcd_host_model_inst.wr(1'b1, 8'h33);
      chk("done", {7'h00, done}, 8'h01);
      words(8'h11, 8'h22, 8'h33, 8'h00, 8'h00, 8'h00);
      // Runtime words by select and bits four and three
      pcd_host_model_inst.wr(1'b1, 8'h44);
      pcd_host_model_inst.wr(1'b0, 8'h03);
      pcd_host_model_inst.wr(1'b0, 8'h0a);
      words(8'h11, 8'h22, 8'h33, 8'h44, 8'h03, 8'h0a);
      chk("pulse two", n_p2[7:0], 8'h01);
      chk("pulse three", n_p3[7:0], 8'h01);
      // Read strobe follows chip select with read low
      pcd_host_model_inst.rd_level(1'b0);
      repeat (4) @(negedge sys_clk);
      chk("read strobe", {7'h00, rstrobe}, 8'h01);
      pcd_host_model_inst.rd_level(1'b1);
      repeat (4) @(negedge sys_clk);
      chk("read strobe", {7'h00, rstrobe}, 8'h00);
      // Single mode without fourth word: first and second setup words only
      pcd_host_model_inst.wr(1'b0, 8'h52);
      chk("done", {7'h00, done}, 8'h00);
      chk("fields", fields, 8'h52);
      pcd_host_model_inst.wr(1'b1, 8'h66);
      chk("setup two", w2, 8'h66);
      chk("setup four", w4, FOURTH_DEFAULT);
      chk("done", {7'h00, done}, 8'h01);
      // Restart in mid-sequence
      pcd_host_model_inst.wr(1'b0, 8'hbd);
      pcd_host_model_inst.wr(1'b1, 8'h77);
      pcd_host_model_inst.wr(1'b0, 8'h13);
      pcd_host_model_inst.wr(1'b1, 8'h88);
      chk("setup two", w2, 8'h88);
      chk("done", {7'h00, done}, 8'h00);
      pcd_host_model_inst.wr(1'b1, 8'h99);
      chk("setup four", w4, 8'h99);
      chk("done", {7'h00, done}, 8'h01);
      // Second reset in mid-run
      do_reset();
      words(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      chk("done", {7'h00, done}, 8'h00);
      end_sim();
   end
endmodule // pcd_decoder_tb
